// ### sim/cwd_bank_properties.sv
// Port-level assertions for the configuration word bank.
`timescale 1ns/100ps
module cwd_bank_properties (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic nvm_rd,
   input wire logic nvm_wr,
   input wire logic nvm_wdone,
   input wire logic partition_swap_instr,
   input wire logic swap_accept,
   input wire logic cfg_ready,
   input wire cwd_pkg::cwd_ctrl_s ctrl
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_swap_gate: assert property (
      swap_accept == (partition_swap_instr & ~ctrl.swap_instr_lock))
      else $error("swap gate wrong");
   a_pair_decode: assert property (
      ctrl.prog_pair_sel == {ctrl.debugger_channel_select == 2'h1,
      ctrl.debugger_channel_select == 2'h2, ctrl.debugger_channel_select == 2'h3})
      else $error("pair decode wrong");
   a_ctrl_hold: assert property (cfg_ready && $past(cfg_ready) |-> $stable(ctrl))
      else $error("ctrl moved");
   a_load_wait: assert property (
      (avs_read || avs_write) && !cfg_ready |-> avs_waitrequest)
      else $error("answer before load");
   a_read_ack: assert property (avs_read && cfg_ready |-> ##[0:1] !avs_waitrequest)
      else $error("read not answered");
   a_wr_pulse: assert property (nvm_wr |-> $past(avs_write) ##1 !nvm_wr)
      else $error("program pulse wrong");
   a_rd_pulse: assert property (nvm_rd |=> !nvm_rd && !cfg_ready)
      else $error("load pulse wrong");
   a_wdone_ack: assert property (nvm_wdone && avs_write |=> !avs_waitrequest)
      else $error("program not acked");
   a_read_pad: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:24] == 8'h00)
      else $error("upper byte set");
endmodule

bind cwd_bank cwd_bank_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .nvm_rd(nvm_rd), .nvm_wr(nvm_wr),
   .nvm_wdone(nvm_wdone), .partition_swap_instr(partition_swap_instr),
   .swap_accept(swap_accept), .cfg_ready(cfg_ready), .ctrl(ctrl));

// ### sim/testbench.sv
// Self-checking bench for the configuration word bank.
`timescale 1ns/100ps
`include "cwd_cfg.svh"
module testbench;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [2:0] nvm_addr;
   logic nvm_rd;
   logic nvm_wr;
   logic [23:0] nvm_rdata = 24'h000000;
   logic nvm_rvalid = 1'b0;
   logic [23:0] nvm_wdata;
   logic nvm_wdone = 1'b0;
   logic partition_swap_instr = 1'b0;
   logic swap_accept;
   logic cfg_ready;
   cwd_pkg::cwd_ctrl_s ctrl;
   cwd_pkg::cwd_ctrl_s exp_ctrl;
   int err_count = 0;
   int total_checks = 0;
   int wr_cnt = 0;
   logic [23:0] wr_data;
   logic [31:0] rd;
   logic [167:0] img;
   // Images other than the all-ones one keep reserved bits fixed; none uses channel code 00.
   logic [167:0] sets [3] = '{{7{24'hFFFFFF}},
      {24'h000084, 24'h000000, 24'h009ABC, 24'h005678, 24'h00ABCD, 24'h001234, 24'h000082},
      {24'h002094, 24'h000001, 24'h00FFFF, 24'h000000, 24'h008000, 24'h00FFFF, 24'h0080A1}};

   always #50 ref_clk = ~ref_clk;

   cwd_bank uut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nvm_addr(nvm_addr),
      .nvm_rd(nvm_rd), .nvm_rdata(nvm_rdata), .nvm_rvalid(nvm_rvalid), .nvm_wr(nvm_wr),
      .nvm_wdata(nvm_wdata), .nvm_wdone(nvm_wdone), .cfg_ready(cfg_ready), .ctrl(ctrl),
      .partition_swap_instr(partition_swap_instr), .swap_accept(swap_accept));

   // Memory answers one cycle late and scrambles its data lines otherwise.
   always @(posedge ref_clk)
   begin
      nvm_rvalid <= nvm_rd;
      nvm_rdata <= nvm_rd ? img[nvm_addr * 24 +: 24] : ~nvm_rdata;
      nvm_wdone <= nvm_wr;
      if (nvm_wr === 1'b1)
      begin
         wr_cnt <= wr_cnt + 1;
         wr_data <= nvm_wdata;
      end
   end

   function automatic logic [23:0] view(input int i, input logic [23:0] raw);
      logic [23:0] im;
      logic [23:0] fm;
      logic [23:0] fv;
      im = (i == 0) ? `CWD_IMPL_DBG : (i == 5) ? `CWD_IMPL_DMT :
         (i == 6) ? `CWD_IMPL_DEVOPT : `CWD_IMPL_HALF;
      fm = (i == 0) ? `CWD_FIXM_DBG : (i == 6) ? `CWD_FIXM_DEVOPT : 24'h000000;
      fv = (i == 0) ? `CWD_FIXV_DBG : (i == 6) ? `CWD_FIXV_DEVOPT : 24'h000000;
      return ((raw & im) | ~im) & ~fm | fv;
   endfunction

   // Expected control outputs for a seven-word image.
   function automatic cwd_pkg::cwd_ctrl_s exp_of(input logic [167:0] m);
      cwd_pkg::cwd_ctrl_s e;
      e.swap_instr_lock = m[15];
      e.test_port_enable = m[5];
      e.debugger_channel_select = m[1:0];
      e.prog_pair_sel = {m[1:0] == 2'h1, m[1:0] == 2'h2, m[1:0] == 2'h3};
      e.deadman_window_interval = {m[63:48], m[39:24]};
      e.deadman_instr_count_limit = {m[111:96], m[87:72]};
      e.deadman_off = m[120];
      e.spi_host2_pin_path = m[157];
      e.smbus_threshold_select = m[154];
      e.i2c_alt_pins = m[149:147];
      return e;
   endfunction

   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request stands until the rising edge that sees waitrequest low; data is taken there.
   task automatic bus(input logic w, input int idx, input logic [23:0] d);
      @(posedge ref_clk);
      avs_address <= 5'(idx * 4);
      avs_read <= ~w;
      avs_write <= w;
      avs_writedata <= {8'h00, d};
      do
      begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      #1000000;
      err_count++;
      tally_and_finish();
   end

   initial
   begin
      for (int k = 0; k < 3; k++)
      begin
         img = sets[k];
         rst_n <= 1'b0;
         repeat (2) @(posedge ref_clk);
         @(negedge ref_clk);
         chk(ctrl, exp_of({7{`CWD_ERASED}}));
         chk(cfg_ready, 1'b0);
         @(posedge ref_clk);
         rst_n <= 1'b1;
         for (int i = 0; i < 7; i++)
         begin
            bus(1'b0, i, 24'h000000);
            chk(rd, {8'h00, view(i, img[i * 24 +: 24])});
         end
         chk(cfg_ready, 1'b1);
         exp_ctrl = exp_of(img);
         chk(ctrl, exp_ctrl);
         partition_swap_instr <= 1'b1;
         @(negedge ref_clk);
         chk(swap_accept, !img[15]);
         @(posedge ref_clk);
         partition_swap_instr <= 1'b0;
         @(negedge ref_clk);
         chk(swap_accept, 1'b0);
         if (k == 0)
         begin
            bus(1'b1, 6, 24'h002094);
            bus(1'b1, 6, 24'h000084);
            bus(1'b1, 7, 24'h000000);
            chk(wr_cnt, 1);
            chk(wr_data, view(6, 24'h002094));
            bus(1'b0, 7, 24'h000000);
            chk(rd, 32'h00004001);
            bus(1'b0, 6, 24'h000000);
            chk(rd, {8'h00, view(6, img[167:144])});
         end
         else
         begin
            bus(1'b1, 0, 24'h000082);
            chk(wr_cnt, 1);
         end
         chk(ctrl, exp_ctrl);
      end
      tally_and_finish();
   end
endmodule

// ### src/cwd_bank.sv
// Program-once configuration word bank with NVM load and Avalon-MM access.
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "cwd_cfg.svh"

module cwd_bank (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [`CWD_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [`CWD_IDX_W-1:0] nvm_addr,
   output logic nvm_rd,
   input wire logic [`CWD_W-1:0] nvm_rdata,
   input wire logic nvm_rvalid,
   output logic nvm_wr,
   output logic [`CWD_W-1:0] nvm_wdata,
   input wire logic nvm_wdone,
   input wire logic partition_swap_instr,
   output logic swap_accept,
   output logic cfg_ready,
   output cwd_pkg::cwd_ctrl_s ctrl
);

   // Implemented-bit mask of a word.
   function automatic cwd_pkg::cwd_word_t impl_mask(
      input logic [`CWD_IDX_W-1:0] idx
   );
      case (idx)
         `CWD_IDX_DBG: impl_mask = `CWD_IMPL_DBG;
         `CWD_IDX_DMT: impl_mask = `CWD_IMPL_DMT;
         `CWD_IDX_DEVOPT: impl_mask = `CWD_IMPL_DEVOPT;
         `CWD_IDX_STAT: impl_mask = '0;
         default: impl_mask = `CWD_IMPL_HALF;
      endcase
   endfunction

   // Fixed reserved-bit mask of a word.
   function automatic cwd_pkg::cwd_word_t fix_mask(
      input logic [`CWD_IDX_W-1:0] idx
   );
      case (idx)
         `CWD_IDX_DBG: fix_mask = `CWD_FIXM_DBG;
         `CWD_IDX_DEVOPT: fix_mask = `CWD_FIXM_DEVOPT;
         default: fix_mask = '0;
      endcase
   endfunction

   // Fixed reserved-bit values of a word.
   function automatic cwd_pkg::cwd_word_t fix_val(
      input logic [`CWD_IDX_W-1:0] idx
   );
      case (idx)
         `CWD_IDX_DBG: fix_val = `CWD_FIXV_DBG;
         `CWD_IDX_DEVOPT: fix_val = `CWD_FIXV_DEVOPT;
         default: fix_val = '0;
      endcase
   endfunction

   // Read view: implemented bits as stored, reserved fixed, others one.
   function automatic cwd_pkg::cwd_word_t word_view(
      input logic [`CWD_IDX_W-1:0] idx,
      input cwd_pkg::cwd_word_t raw
   );
      cwd_pkg::cwd_word_t im;
      cwd_pkg::cwd_word_t fm;
      im = impl_mask(idx);
      fm = fix_mask(idx);
      word_view = (raw & im) | ~(im | fm) | fix_val(idx);
   endfunction

   cwd_pkg::cwd_state_e state_reg;
   cwd_pkg::cwd_state_e state_next;
   cwd_pkg::cwd_word_t shadow_reg [`CWD_NWORDS];
   cwd_pkg::cwd_word_t shadow_next [`CWD_NWORDS];
   logic [`CWD_IDX_W-1:0] idx_reg;
   logic [`CWD_IDX_W-1:0] idx_next;
   logic [`CWD_NWORDS-1:0] prog_reg;
   logic [`CWD_NWORDS-1:0] prog_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic nvm_rd_reg;
   logic nvm_rd_next;
   logic nvm_wr_reg;
   logic nvm_wr_next;
   cwd_pkg::cwd_word_t wdata_reg;
   cwd_pkg::cwd_word_t wdata_next;
   logic [`CWD_IDX_W-1:0] req_idx;
   logic req_hit;
   logic busy;
   logic erased;
   cwd_pkg::cwd_word_t cur_raw;
   cwd_pkg::cwd_word_t cur_view;
   cwd_pkg::cwd_word_t dbg_w;
   cwd_pkg::cwd_word_t opt_w;

   assign req_idx = avs_address[`CWD_ADDR_W-1:2];
   assign req_hit = (req_idx <= `CWD_LAST_IDX);
   assign cur_view = word_view(req_idx, cur_raw);
   // A word counts as erased while every implemented bit still reads one.
   assign erased = ((cur_view & impl_mask(req_idx)) == impl_mask(req_idx));
   assign busy = (state_reg != cwd_pkg::CWD_RUN);
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
   assign avs_readdata = rdata_reg;
   assign nvm_addr = idx_reg;
   assign nvm_rd = nvm_rd_reg;
   assign nvm_wr = nvm_wr_reg;
   assign nvm_wdata = wdata_reg;
   assign cfg_ready = ~busy | (state_reg == cwd_pkg::CWD_PROG_WAIT);

   // The status index has no stored word, so the array is read only in range.
   always_comb
   begin
      cur_raw = `CWD_ERASED;
      if (req_hit)
      begin
         cur_raw = shadow_reg[req_idx];
      end
   end

   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      prog_next = prog_reg;
      ack_next = 1'b0;
      rdata_next = rdata_reg;
      nvm_rd_next = 1'b0;
      nvm_wr_next = 1'b0;
      wdata_next = wdata_reg;
      for (int i = 0; i < `CWD_NWORDS; i++)
      begin
         shadow_next[i] = shadow_reg[i];
      end
      case (state_reg)
         cwd_pkg::CWD_LOAD_REQ:
         begin
            nvm_rd_next = 1'b1;
            state_next = cwd_pkg::CWD_LOAD_WAIT;
         end
         cwd_pkg::CWD_LOAD_WAIT:
         begin
            if (nvm_rvalid)
            begin
               shadow_next[idx_reg] = nvm_rdata;
               if (idx_reg == `CWD_LAST_IDX)
               begin
                  idx_next = '0;
                  state_next = cwd_pkg::CWD_RUN;
               end
               else
               begin
                  idx_next = idx_reg + 3'h1;
                  state_next = cwd_pkg::CWD_LOAD_REQ;
               end
            end
         end
         cwd_pkg::CWD_RUN:
         begin
            if ((avs_read | avs_write) & ~ack_reg)
            begin
               ack_next = 1'b1;
               if (avs_read)
               begin
                  if (req_idx == `CWD_IDX_STAT)
                  begin
                     rdata_next = '0;
                     rdata_next[`CWD_STAT_READY_BIT] = 1'b1;
                     rdata_next[`CWD_STAT_PROG_LSB +: `CWD_NWORDS] = prog_reg;
                  end
                  else if (req_hit)
                  begin
                     rdata_next = {8'h00, cur_view};
                  end
                  else
                  begin
                     rdata_next = `CWD_RD_UNMAPPED;
                  end
               end
               else if (req_hit & erased & ~prog_reg[req_idx])
               begin
                  // One program per word per reset; outputs keep loaded value.
                  prog_next[req_idx] = 1'b1;
                  idx_next = req_idx;
                  wdata_next = word_view(req_idx, avs_writedata[`CWD_W-1:0]);
                  nvm_wr_next = 1'b1;
                  ack_next = 1'b0;
                  state_next = cwd_pkg::CWD_PROG_WAIT;
               end
            end
         end
         cwd_pkg::CWD_PROG_WAIT:
         begin
            if (nvm_wdone)
            begin
               ack_next = 1'b1;
               state_next = cwd_pkg::CWD_RUN;
            end
         end
         default:
         begin
            state_next = cwd_pkg::CWD_LOAD_REQ;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= cwd_pkg::CWD_LOAD_REQ;
         idx_reg <= '0;
         prog_reg <= '0;
         ack_reg <= 1'b0;
         rdata_reg <= '0;
         nvm_rd_reg <= 1'b0;
         nvm_wr_reg <= 1'b0;
         wdata_reg <= '0;
         for (int i = 0; i < `CWD_NWORDS; i++)
         begin
            shadow_reg[i] <= `CWD_ERASED;
         end
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         prog_reg <= prog_next;
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         nvm_rd_reg <= nvm_rd_next;
         nvm_wr_reg <= nvm_wr_next;
         wdata_reg <= wdata_next;
         for (int i = 0; i < `CWD_NWORDS; i++)
         begin
            shadow_reg[i] <= shadow_next[i];
         end
      end
   end

   assign dbg_w = word_view(`CWD_IDX_DBG, shadow_reg[`CWD_IDX_DBG]);
   assign opt_w = word_view(`CWD_IDX_DEVOPT, shadow_reg[`CWD_IDX_DEVOPT]);

   // Swap instruction passes only when the lock bit is clear.
   assign swap_accept = partition_swap_instr & ~ctrl.swap_instr_lock;

   assign ctrl.swap_instr_lock = dbg_w[`CWD_SWAP_BIT];
   assign ctrl.test_port_enable = dbg_w[`CWD_JTAG_BIT];
   assign ctrl.debugger_channel_select = dbg_w[`CWD_ICS_LSB +: 2];

   // Channel code to one-hot pair enable; the reserved code selects no pair at all.
   function automatic logic [2:0] pair_decode(
      input logic [1:0] code
   );
      case (code)
         `CWD_ICS_PAIR1: pair_decode = 3'h1;
         `CWD_ICS_PAIR2: pair_decode = 3'h2;
         `CWD_ICS_PAIR3: pair_decode = 3'h4;
         default: pair_decode = 3'h0;
      endcase
   endfunction

   assign ctrl.prog_pair_sel = pair_decode(ctrl.debugger_channel_select);

   assign ctrl.deadman_window_interval = {
      shadow_reg[`CWD_IDX_IVTH][`CWD_HALF-1:0],
      shadow_reg[`CWD_IDX_IVTL][`CWD_HALF-1:0]};
   assign ctrl.deadman_instr_count_limit = {
      shadow_reg[`CWD_IDX_CNTH][`CWD_HALF-1:0],
      shadow_reg[`CWD_IDX_CNTL][`CWD_HALF-1:0]};
   assign ctrl.deadman_off = shadow_reg[`CWD_IDX_DMT][`CWD_DEADMAN_OFF_BIT];
   assign ctrl.spi_host2_pin_path = opt_w[`CWD_SPI2_BIT];
   assign ctrl.smbus_threshold_select = opt_w[`CWD_SMB_BIT];

   genvar g;
   generate
      for (g = 0; g < `CWD_NI2C; g++)
      begin : g_i2c
         assign ctrl.i2c_alt_pins[g] = opt_w[`CWD_I2C1_BIT + g];
      end
   endgenerate

endmodule

// ### src/cwd_cfg.svh
// Constants for the configuration word decode bank.
`ifndef CWD_CFG_SVH
`define CWD_CFG_SVH
`define CWD_W 24
`define CWD_NWORDS 7
`define CWD_IDX_W 3
`define CWD_ADDR_W 5
`define CWD_IDX_DBG 3'h0
`define CWD_IDX_IVTL 3'h1
`define CWD_IDX_IVTH 3'h2
`define CWD_IDX_CNTL 3'h3
`define CWD_IDX_CNTH 3'h4
`define CWD_IDX_DMT 3'h5
`define CWD_IDX_DEVOPT 3'h6
`define CWD_IDX_STAT 3'h7
`define CWD_LAST_IDX 3'h6
`define CWD_IMPL_DBG 24'h008023
`define CWD_IMPL_HALF 24'h00FFFF
`define CWD_IMPL_DMT 24'h000001
`define CWD_IMPL_DEVOPT 24'h002438
`define CWD_FIXM_DBG 24'h000080
`define CWD_FIXV_DBG 24'h000080
`define CWD_FIXM_DEVOPT 24'h000384
`define CWD_FIXV_DEVOPT 24'h000084
`define CWD_HALF 16
`define CWD_SWAP_BIT 15
`define CWD_JTAG_BIT 5
`define CWD_ICS_LSB 0
`define CWD_DEADMAN_OFF_BIT 0
`define CWD_SPI2_BIT 13
`define CWD_SMB_BIT 10
`define CWD_I2C1_BIT 3
`define CWD_NI2C 3
`define CWD_ICS_PAIR1 2'h3
`define CWD_ICS_PAIR2 2'h2
`define CWD_ICS_PAIR3 2'h1
`define CWD_STAT_READY_BIT 0
`define CWD_STAT_PROG_LSB 8
`define CWD_ERASED 24'hFFFFFF
`define CWD_RD_UNMAPPED 32'h00000000
`endif

// ### src/cwd_pkg.sv
// Types shared by the configuration word decode bank.
package cwd_pkg;
   typedef enum logic [2:0] {
      CWD_LOAD_REQ,
      CWD_LOAD_WAIT,
      CWD_RUN,
      CWD_PROG_WAIT
   } cwd_state_e;

   typedef struct packed {
      logic swap_instr_lock;
      logic test_port_enable;
      logic [1:0] debugger_channel_select;
      logic [2:0] prog_pair_sel;
      logic [31:0] deadman_window_interval;
      logic [31:0] deadman_instr_count_limit;
      logic deadman_off;
      logic spi_host2_pin_path;
      logic smbus_threshold_select;
      logic [2:0] i2c_alt_pins;
   } cwd_ctrl_s;

   typedef logic [23:0] cwd_word_t;
endpackage
